// >>> shared/sapr_defs.svh
`ifndef SAPR_DEFS_SVH
`define SAPR_DEFS_SVH

// ************************************************************
// register offsets (byte addresses of the local map)
// ************************************************************
`define SAPR_ADDR_ALIAS_LO 16'h0012
`define SAPR_ADDR_ALIAS_HI 16'h0013
`define SAPR_ADDR_REG_UNLOCK 16'h0020
`define SAPR_ADDR_REG_GUARD 16'h0021
`define SAPR_ADDR_CTL_UNLOCK 16'h0030
`define SAPR_ADDR_CTL_GUARD 16'h0031
`define SAPR_ADDR_NET_KEY 16'h0040
`define SAPR_ADDR_HOST_KEY 16'h0041

// ************************************************************
// fields, keys and reset values
// ************************************************************
`define SAPR_GUARD_BIT 0
`define SAPR_REG_AREA_END 16'h1000
`define SAPR_KEY_FIRST 8'h52
`define SAPR_KEY_SECOND 8'h45
`define SAPR_KEY_THIRD 8'h53
`define SAPR_ALIAS_RESET 16'h0000
`define SAPR_BYTE_RESET 8'h00

`endif

// >>> shared/sapr_pkg.sv
package sapr_pkg;

    // progress of a reset key sequence, codes equal the read value
    typedef enum logic [1:0] {
        SAPR_KEY_IDLE = 2'b00,
        SAPR_KEY_GOT1 = 2'b01,
        SAPR_KEY_GOT2 = 2'b10
    } sapr_key_state_t;

endpackage

// >>> rtl/sapr_top.sv
`timescale 1ns/1ns
`include "sapr_defs.svh"

// Overview of operation
// - 16-bit alias, network side read-only, host side read and write.
// - alias serves addressing only while link-layer control bit 24 is set.
// - alias taken from EEPROM word 4 only on first load after reset.
// - register guard on: unlock write needed earlier in frame, else refused.
// - register guard stays on after the frame unless its setting changed.
// - register guard bit 0 enables; network writes, host reads; resets 0.
// - controller guard on: unlock write needed earlier in frame, else refused.
// - controller guard bit 0 enables; network writes, host reads; resets 0.
// - network key register: 52, 45, 53 in three frames asserts reset.
// - host key register: 52, 45, 53 in three host writes asserts reset.
// - key register reads progress: 01 after first, 10 after second, else 00.
module sapr_top
    import sapr_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // network side byte access
    input wire logic i_net_frame_end,
    input wire logic i_net_wr,
    input wire logic [ADDR_W-1:0] i_net_addr,
    input wire logic [7:0] i_net_wdata,
    output logic o_net_wr_allow,
    output logic [7:0] o_net_rdata,
    // host side byte access
    input wire logic i_host_wr,
    input wire logic [ADDR_W-1:0] i_host_addr,
    input wire logic [7:0] i_host_wdata,
    output logic [7:0] o_host_rdata,
    // eeprom loader and link-layer control
    input wire logic i_eeprom_load_done,
    input wire logic [15:0] i_eeprom_alias,
    input wire logic i_alias_enable,
    // addressing and reset request
    output logic [15:0] o_alias,
    output logic o_alias_active,
    output logic o_reset_req
);

    // ************************************************************
    // reset release
    // ************************************************************
    logic [1:0] rst_sync_reg;
    logic rst_n;

    // async assert, two-flop release keeps recovery off the data path
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ************************************************************
    // write protection
    // ************************************************************
    logic reg_guard_reg, reg_guard_next;
    logic ctl_guard_reg, ctl_guard_next;
    logic reg_open_reg, reg_open_next;
    logic ctl_open_reg, ctl_open_next;
    logic in_reg_area;
    logic to_reg_unlock;
    logic to_ctl_unlock;
    logic net_wr_ok;

    // decode of the target of the current network write
    assign in_reg_area = (i_net_addr < ADDR_W'(`SAPR_REG_AREA_END));
    assign to_reg_unlock = (i_net_addr == ADDR_W'(`SAPR_ADDR_REG_UNLOCK));
    assign to_ctl_unlock = (i_net_addr == ADDR_W'(`SAPR_ADDR_CTL_UNLOCK));

    // the controller unlock is always writable; the register unlock passes the register guard only
    always_comb begin
        net_wr_ok = 1'b1;
        if (reg_guard_reg && !reg_open_reg && in_reg_area &&
            !to_reg_unlock && !to_ctl_unlock) begin
            net_wr_ok = 1'b0;
        end
        if (ctl_guard_reg && !ctl_open_reg && !to_ctl_unlock) begin
            net_wr_ok = 1'b0;
        end
    end
    assign o_net_wr_allow = net_wr_ok;

    // unlock flags live for one frame; guard bits persist across frames
    always_comb begin
        reg_guard_next = reg_guard_reg;
        ctl_guard_next = ctl_guard_reg;
        reg_open_next = reg_open_reg;
        ctl_open_next = ctl_open_reg;
        if (i_net_frame_end) begin
            reg_open_next = 1'b0;
            ctl_open_next = 1'b0;
        end
        // set after clear: an unlock in the last cycle is not lost;
        // a register unlock refused by the controller guard opens nothing
        if (i_net_wr && to_reg_unlock && net_wr_ok) begin
            reg_open_next = 1'b1;
        end
        if (i_net_wr && to_ctl_unlock) begin
            ctl_open_next = 1'b1;
        end
        if (i_net_wr && net_wr_ok) begin
            if (i_net_addr == ADDR_W'(`SAPR_ADDR_REG_GUARD)) begin
                reg_guard_next = i_net_wdata[`SAPR_GUARD_BIT];
            end
            if (i_net_addr == ADDR_W'(`SAPR_ADDR_CTL_GUARD)) begin
                ctl_guard_next = i_net_wdata[`SAPR_GUARD_BIT];
            end
        end
    end

    // protection state
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_guard_reg <= 1'b0;
            ctl_guard_reg <= 1'b0;
            reg_open_reg <= 1'b0;
            ctl_open_reg <= 1'b0;
        end else begin
            reg_guard_reg <= reg_guard_next;
            ctl_guard_reg <= ctl_guard_next;
            reg_open_reg <= reg_open_next;
            ctl_open_reg <= ctl_open_next;
        end
    end

    // ************************************************************
    // station alias
    // ************************************************************
    logic [15:0] alias_reg, alias_next;
    logic loaded_reg, loaded_next;

    // host writes either byte; eeprom only before its first load
    always_comb begin
        alias_next = alias_reg;
        loaded_next = loaded_reg;
        if (i_eeprom_load_done && !loaded_reg) begin
            alias_next = i_eeprom_alias;
        end
        if (i_eeprom_load_done) begin
            loaded_next = 1'b1;
        end
        if (i_host_wr &&
            i_host_addr == ADDR_W'(`SAPR_ADDR_ALIAS_LO)) begin
            alias_next[7:0] = i_host_wdata;
        end
        if (i_host_wr &&
            i_host_addr == ADDR_W'(`SAPR_ADDR_ALIAS_HI)) begin
            alias_next[15:8] = i_host_wdata;
        end
    end

    // alias state
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            alias_reg <= `SAPR_ALIAS_RESET;
            loaded_reg <= 1'b0;
        end else begin
            alias_reg <= alias_next;
            loaded_reg <= loaded_next;
        end
    end

    assign o_alias = alias_reg;
    assign o_alias_active = i_alias_enable;

    // ************************************************************
    // reset key sequences, index 0 network side, 1 host side
    // ************************************************************
    logic [1:0] key_wr;
    logic [7:0] key_data [2];
    sapr_key_state_t key_state_reg [2];
    sapr_key_state_t key_state_next [2];
    logic [1:0] key_fire_reg, key_fire_next;

    // network key writes pass the guards; one write per frame expected
    assign key_wr[0] = i_net_wr && net_wr_ok &&
        (i_net_addr == ADDR_W'(`SAPR_ADDR_NET_KEY));
    assign key_wr[1] = i_host_wr &&
        (i_host_addr == ADDR_W'(`SAPR_ADDR_HOST_KEY));
    assign key_data[0] = i_net_wdata;
    assign key_data[1] = i_host_wdata;

    genvar gk;
    generate
        for (gk = 0; gk < 2; gk++) begin : g_key
            // a first key byte always restarts, even mid-sequence
            always_comb begin
                key_state_next[gk] = key_state_reg[gk];
                key_fire_next[gk] = 1'b0;
                if (key_wr[gk]) begin
                    key_state_next[gk] = SAPR_KEY_IDLE;
                    if (key_data[gk] == `SAPR_KEY_FIRST) begin
                        key_state_next[gk] = SAPR_KEY_GOT1;
                    end else if (key_data[gk] == `SAPR_KEY_SECOND &&
                                 key_state_reg[gk] == SAPR_KEY_GOT1) begin
                        key_state_next[gk] = SAPR_KEY_GOT2;
                    end else if (key_data[gk] == `SAPR_KEY_THIRD &&
                                 key_state_reg[gk] == SAPR_KEY_GOT2) begin
                        key_fire_next[gk] = 1'b1;
                    end
                end
            end

            // sequence state
            always_ff @(posedge i_sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    key_state_reg[gk] <= SAPR_KEY_IDLE;
                    key_fire_reg[gk] <= 1'b0;
                end else begin
                    key_state_reg[gk] <= key_state_next[gk];
                    key_fire_reg[gk] <= key_fire_next[gk];
                end
            end
        end
    endgenerate

    // one-cycle request; the reset distribution stretches it as needed
    assign o_reset_req = |key_fire_reg;

    // ************************************************************
    // read data
    // ************************************************************
    logic [7:0] net_rdata_reg, net_rdata_next;
    logic [7:0] host_rdata_reg, host_rdata_next;

    // registered read; unmapped and write-only bytes read zero
    always_comb begin
        net_rdata_next = `SAPR_BYTE_RESET;
        unique case (i_net_addr)
            ADDR_W'(`SAPR_ADDR_ALIAS_LO):
                net_rdata_next = alias_reg[7:0];
            ADDR_W'(`SAPR_ADDR_ALIAS_HI):
                net_rdata_next = alias_reg[15:8];
            ADDR_W'(`SAPR_ADDR_REG_GUARD):
                net_rdata_next = {7'h00, reg_guard_reg};
            ADDR_W'(`SAPR_ADDR_CTL_GUARD):
                net_rdata_next = {7'h00, ctl_guard_reg};
            ADDR_W'(`SAPR_ADDR_NET_KEY):
                net_rdata_next = {6'h00, key_state_reg[0]};
            default: net_rdata_next = `SAPR_BYTE_RESET;
        endcase
    end

    // host view of the same bytes, plus the host key register
    always_comb begin
        host_rdata_next = `SAPR_BYTE_RESET;
        unique case (i_host_addr)
            ADDR_W'(`SAPR_ADDR_ALIAS_LO):
                host_rdata_next = alias_reg[7:0];
            ADDR_W'(`SAPR_ADDR_ALIAS_HI):
                host_rdata_next = alias_reg[15:8];
            ADDR_W'(`SAPR_ADDR_REG_GUARD):
                host_rdata_next = {7'h00, reg_guard_reg};
            ADDR_W'(`SAPR_ADDR_CTL_GUARD):
                host_rdata_next = {7'h00, ctl_guard_reg};
            ADDR_W'(`SAPR_ADDR_NET_KEY):
                host_rdata_next = {6'h00, key_state_reg[0]};
            ADDR_W'(`SAPR_ADDR_HOST_KEY):
                host_rdata_next = {6'h00, key_state_reg[1]};
            default: host_rdata_next = `SAPR_BYTE_RESET;
        endcase
    end

    // read registers
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            net_rdata_reg <= `SAPR_BYTE_RESET;
            host_rdata_reg <= `SAPR_BYTE_RESET;
        end else begin
            net_rdata_reg <= net_rdata_next;
            host_rdata_reg <= host_rdata_next;
        end
    end

    assign o_net_rdata = net_rdata_reg;
    assign o_host_rdata = host_rdata_reg;

endmodule // sapr_top

// >>> dv/sapr_checker.sv
`timescale 1ns/1ns
`include "sapr_defs.svh"
module sapr_checker #(
    parameter int ADDR_W = 16
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // network side
    input wire logic i_net_wr,
    input wire logic [ADDR_W-1:0] i_net_addr,
    input wire logic [7:0] i_net_wdata,
    input wire logic o_net_wr_allow,
    // host side
    input wire logic i_host_wr,
    input wire logic [ADDR_W-1:0] i_host_addr,
    input wire logic [7:0] i_host_wdata,
    input wire logic [7:0] o_host_rdata,
    // alias and reset request
    input wire logic i_eeprom_load_done,
    input wire logic i_alias_enable,
    input wire logic [15:0] o_alias,
    input wire logic o_alias_active,
    input wire logic o_reset_req
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_reset_n);
    // ************************************************************
    // accepted key bytes
    // ************************************************************
    sequence s_host(k);
        i_host_wr && i_host_addr == `SAPR_ADDR_HOST_KEY && i_host_wdata == k;
    endsequence
    sequence s_net(k);
        i_net_wr && o_net_wr_allow && i_net_addr == `SAPR_ADDR_NET_KEY
            && i_net_wdata == k;
    endsequence
    // a closing key byte on either side, the only cause of a request
    logic third_seen;
    assign third_seen = i_host_wr && i_host_addr == `SAPR_ADDR_HOST_KEY
        && i_host_wdata == `SAPR_KEY_THIRD || i_net_wr && o_net_wr_allow
        && i_net_addr == `SAPR_ADDR_NET_KEY && i_net_wdata == `SAPR_KEY_THIRD;

    a_host_key_fire: assert property (
        s_host(`SAPR_KEY_FIRST) ##1 s_host(`SAPR_KEY_SECOND)
        ##1 s_host(`SAPR_KEY_THIRD) |=> o_reset_req)
        else $error("host key gave no reset request");
    a_net_key_fire: assert property (
        s_net(`SAPR_KEY_FIRST) ##1 !i_net_wr [*2] ##1 s_net(`SAPR_KEY_SECOND)
        ##1 !i_net_wr [*2] ##1 s_net(`SAPR_KEY_THIRD) |=> o_reset_req)
        else $error("network key gave no reset request");
    a_reset_single: assert property (o_reset_req |=> !o_reset_req)
        else $error("reset request longer than one cycle");
    a_reset_cause: assert property (
        $rose(o_reset_req) |-> $past(third_seen))
        else $error("reset request without a closing key byte");
    a_alias_follow: assert property (
        o_alias_active == i_alias_enable)
        else $error("alias active does not follow its enable");
    a_alias_stable: assert property (
        !i_eeprom_load_done && !i_host_wr |=> $stable(o_alias))
        else $error("alias changed without host write or load");
    a_ctl_unlock_ok: assert property (
        i_net_addr == `SAPR_ADDR_CTL_UNLOCK |-> o_net_wr_allow)
        else $error("controller unlock write refused");
    a_key_progress: assert property (
        s_host(`SAPR_KEY_FIRST) ##1 (i_host_addr == `SAPR_ADDR_HOST_KEY
        && !i_host_wr) |=> o_host_rdata == 8'h01)
        else $error("progress not 01 after first key byte");
endmodule // sapr_checker

bind sapr_top sapr_checker #(.ADDR_W(ADDR_W)) u_checker (.*);

// >>> dv/sapr_net_master.sv
`timescale 1ns/1ns
module sapr_net_master (
    // clock
    input wire logic i_sys_clk,
    // network side byte access
    output logic o_wr,
    output logic [15:0] o_addr,
    output logic [7:0] o_wdata,
    output logic o_frame_end
);
    // idle bus at time zero
    initial begin
        o_wr = 1'h0;
        o_addr = 16'h0000;
        o_wdata = 8'h00;
        o_frame_end = 1'h0;
    end
    // one byte write, the frame closed after it when last is set
    task automatic send(input logic [15:0] a, input logic [7:0] d,
        input logic last);
        @(posedge i_sys_clk);
        o_wr <= 1'h1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_sys_clk);
        o_wr <= 1'h0;
        o_wdata <= ~d; // released data must not look like the last byte
        o_frame_end <= last;
        @(posedge i_sys_clk);
        o_frame_end <= 1'h0;
    endtask
    // present an address without a write, to probe the permission
    task automatic aim(input logic [15:0] a);
        @(posedge i_sys_clk);
        o_addr <= a;
        @(posedge i_sys_clk);
    endtask
endmodule // sapr_net_master

// >>> dv/station_alias_protect_reset_test.sv
`timescale 1ns/1ns
`include "sapr_defs.svh"
module station_alias_protect_reset_test;
    import sapr_pkg::*;
    typedef struct packed {
        logic wr;
        logic [15:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } sapr_row_t;
    logic i_sys_clk = 1'h0, i_reset_n = 1'h0, i_host_wr = 1'h0;
    logic i_eeprom_load_done = 1'h0, i_alias_enable = 1'h0;
    logic [15:0] i_host_addr = 16'h0000, i_eeprom_alias = 16'h0000;
    logic [7:0] i_host_wdata = 8'h00;
    logic i_net_frame_end, i_net_wr, o_net_wr_allow, o_alias_active;
    logic o_reset_req;
    logic [15:0] i_net_addr, o_alias;
    logic [7:0] i_net_wdata, o_net_rdata, o_host_rdata;
    int errors = 0, num_checks = 0, pulses = 0;
    // host access, then read back what the host should see
    sapr_row_t rows [12] = '{
        '{1'h0, 16'h0021, 8'h00, 8'h00}, '{1'h0, 16'h0031, 8'h00, 8'h00},
        '{1'h0, 16'h0040, 8'h00, 8'h00}, '{1'h0, 16'h0041, 8'h00, 8'h00},
        '{1'h1, 16'h0012, 8'h34, 8'h34}, '{1'h1, 16'h0013, 8'hAB, 8'hAB},
        '{1'h1, 16'h0021, 8'h01, 8'h00}, '{1'h1, 16'h0031, 8'h01, 8'h00},
        '{1'h1, 16'h0041, 8'h52, 8'h01}, '{1'h1, 16'h0041, 8'h45, 8'h02},
        '{1'h1, 16'h0041, 8'h11, 8'h00}, '{1'h1, 16'h0040, 8'h52, 8'h00}
    };
    sapr_top #(.ADDR_W(16)) dut (.*);
    sapr_net_master net (
        .i_sys_clk(i_sys_clk),
        .o_wr(i_net_wr),
        .o_addr(i_net_addr),
        .o_wdata(i_net_wdata),
        .o_frame_end(i_net_frame_end)
    );
    // 4 ns clock
    initial begin
        forever #2 i_sys_clk = ~i_sys_clk;
    end
    // count reset requests; a stretched pulse would count twice
    always @(posedge i_sys_clk)
        if (o_reset_req === 1'h1)
            pulses <= pulses + 1;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic hw(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_host_wr <= 1'h1;
        i_host_addr <= a;
        i_host_wdata <= d;
        @(posedge i_sys_clk);
        i_host_wr <= 1'h0;
        i_host_wdata <= ~d;
    endtask
    task automatic hr(input logic [15:0] a, input logic [7:0] e);
        @(posedge i_sys_clk);
        i_host_addr <= a;
        @(posedge i_sys_clk);
        #1 chk(o_host_rdata, e);
    endtask
    task automatic ee(input logic [15:0] v);
        @(posedge i_sys_clk);
        i_eeprom_load_done <= 1'h1;
        i_eeprom_alias <= v;
        @(posedge i_sys_clk);
        i_eeprom_load_done <= 1'h0;
        i_eeprom_alias <= ~v;
        #1;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge i_sys_clk);
        errors++;
        tally_and_finish;
    end
    initial begin
        repeat (2) @(posedge i_sys_clk);
        i_reset_n <= 1'h1;
        repeat (2) @(posedge i_sys_clk);
        foreach (rows[i]) begin
            if (rows[i].wr)
                hw(rows[i].a, rows[i].d);
            hr(rows[i].a, rows[i].e);
        end
        $display("register table test done");
        ee(16'h1234);
        chk(o_alias, 16'h1234);
        ee(16'h5678);
        chk(o_alias, 16'h1234);
        @(posedge i_sys_clk) i_alias_enable <= 1'h1;
        #1 chk(o_alias_active, 16'h0001);
        $display("alias test done");
        net.send(`SAPR_ADDR_REG_GUARD, 8'h01, 1'h1);
        hr(`SAPR_ADDR_REG_GUARD, 8'h01);
        net.send(`SAPR_ADDR_NET_KEY, `SAPR_KEY_FIRST, 1'h0);
        hr(`SAPR_ADDR_NET_KEY, 8'h00);
        net.send(`SAPR_ADDR_REG_UNLOCK, 8'hAA, 1'h0);
        net.send(`SAPR_ADDR_NET_KEY, `SAPR_KEY_FIRST, 1'h1);
        hr(`SAPR_ADDR_NET_KEY, 8'h01);
        net.aim(`SAPR_ADDR_NET_KEY);
        #1 chk(o_net_wr_allow, 16'h0000);
        chk(o_net_rdata, 16'h0001);
        net.send(`SAPR_ADDR_REG_UNLOCK, 8'h00, 1'h0);
        net.send(`SAPR_ADDR_REG_GUARD, 8'h00, 1'h1);
        hr(`SAPR_ADDR_REG_GUARD, 8'h00);
        $display("register guard test done");
        net.send(`SAPR_ADDR_CTL_GUARD, 8'h01, 1'h1);
        hr(`SAPR_ADDR_CTL_GUARD, 8'h01);
        net.aim(`SAPR_ADDR_REG_UNLOCK);
        #1 chk(o_net_wr_allow, 16'h0000);
        net.send(`SAPR_ADDR_CTL_UNLOCK, 8'h00, 1'h0);
        net.send(`SAPR_ADDR_CTL_GUARD, 8'h00, 1'h1);
        hr(`SAPR_ADDR_CTL_GUARD, 8'h00);
        // network side may read the alias but never write it
        net.send(`SAPR_ADDR_ALIAS_HI, 8'h55, 1'h1);
        net.aim(`SAPR_ADDR_ALIAS_HI);
        #1 chk(o_net_rdata, 16'h0012);
        chk(o_alias, 16'h1234);
        $display("controller guard test done");
        net.send(`SAPR_ADDR_NET_KEY, `SAPR_KEY_FIRST, 1'h1);
        net.send(`SAPR_ADDR_NET_KEY, `SAPR_KEY_SECOND, 1'h1);
        net.send(`SAPR_ADDR_NET_KEY, `SAPR_KEY_THIRD, 1'h1);
        repeat (2) @(posedge i_sys_clk);
        #1 chk(16'(pulses), 16'h0001);
        @(posedge i_sys_clk);
        i_host_wr <= 1'h1;
        i_host_addr <= `SAPR_ADDR_HOST_KEY;
        i_host_wdata <= `SAPR_KEY_FIRST;
        @(posedge i_sys_clk) i_host_wdata <= `SAPR_KEY_SECOND;
        @(posedge i_sys_clk) i_host_wdata <= `SAPR_KEY_THIRD;
        @(posedge i_sys_clk) i_host_wr <= 1'h0;
        repeat (2) @(posedge i_sys_clk);
        #1 chk(16'(pulses), 16'h0002);
        hr(`SAPR_ADDR_HOST_KEY, 8'h00);
        $display("key sequence test done");
        @(posedge i_sys_clk) i_reset_n <= 1'h0;
        @(posedge i_sys_clk) i_reset_n <= 1'h1;
        repeat (2) @(posedge i_sys_clk);
        #1 chk(o_alias, `SAPR_ALIAS_RESET);
        ee(16'h9ABC);
        chk(o_alias, 16'h9ABC);
        $display("second reset test done");
        tally_and_finish;
    end
endmodule // station_alias_protect_reset_test
